// ### etg_defs.svh
`ifndef ETG_DEFS_SVH
`define ETG_DEFS_SVH

// register indices; byte address is four times the index
`define ETG_IDX_EEE 5'h11
`define ETG_IDX_STAT 5'h1c
`define ETG_IDX_CTRL1 5'h1d
`define ETG_IDX_PAT 5'h1e
`define ETG_IDX_PAGE 5'h1f
`define ETG_IDX_STD_TOP 5'h0f
`define ETG_PAGE_STD 16'h0000
`define ETG_PAGE_ONE 16'h0001
`define ETG_PAGE_TWO 16'h0002

// control one, eee and status register fields
`define ETG_B_EN 15
`define ETG_B_RUN 14
`define ETG_B_DUR 13
`define ETG_F_LEN_HI 12
`define ETG_F_LEN_LO 11
`define ETG_B_IPG 10
`define ETG_F_DA_HI 9
`define ETG_F_DA_LO 6
`define ETG_F_SA_HI 5
`define ETG_F_SA_LO 2
`define ETG_B_PAY 1
`define ETG_B_FCS 0
`define ETG_B_LPI 4
`define ETG_B_ST_BUSY 0
`define ETG_B_ST_DONE 1
`define ETG_B_ST_LPI 2

`define ETG_CTRL1_RST 16'h0040
`define ETG_PAT_RST 16'h0000

// frame layout
`define ETG_LEN_00 14'h007d
`define ETG_LEN_01 14'h0040
`define ETG_LEN_10 14'h05ee
`define ETG_LEN_11 14'h2710
`define ETG_ADDR_BYTES 14'h0006
`define ETG_FCS_BYTES 14'h0004
`define ETG_ALL_ONES 8'hff
`define ETG_NIB_ONES 4'hf

// timing
`define ETG_CLK_MHZ 125
`define ETG_LINE_MBPS 1000
`define ETG_IPG_SHORT_BITS 96
`define ETG_IPG_LONG_BITS 8192
`define ETG_BLOCK_FRAMES 10000
`define ETG_BURST_FRAMES 30000000

`define ETG_CRC_POLY 32'hedb88320
`define ETG_CRC_INIT 32'hffffffff
`define ETG_LFSR_SEED 16'hace1
`define ETG_LFSR_TAPS 16'hb400
`define ETG_FIFO_DEPTH 4

`endif

// ### etg_pkg.sv
package etg_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DA = 3'h1,
    ST_SA = 3'h3,
    ST_PAY = 3'h2,
    ST_FCS = 3'h6,
    ST_GAP = 3'h7
  } etg_state_t;

  // one byte slot toward the medium; en low marks an idle slot
  typedef struct packed {
    logic en;
    logic last;
    logic [7:0] data;
  } etg_word_t;

  // settings frozen at the start of a run
  typedef struct packed {
    logic dur;
    logic [1:0] len;
    logic ipg;
    logic [3:0] da;
    logic [3:0] sa;
    logic pay;
    logic bad_fcs;
    logic [15:0] pattern;
  } etg_cfg_t;

endpackage

// ### etg_gen.sv
// Function
// - continuous mode counts blocks of ten thousand; else burst then stop.
// - continuous cleared mid-run stops at next ten-thousand frame mark.
// - length code selects 125, 64, 1518 or 10000 byte frames.
// - gap bit clear selects 96, set 8192 bit times of idle between frames.
// - destination address all ones, low nibble from field, reset 0001.
// - source address all ones, low nibble from field, reset 0000.
// - payload type set gives random payload, clear gives fixed pattern.
// - frame check bit set appends a wrong FCS, clear a correct one.
// - fixed payload repeats the sixteen-bit pattern register, reset zero.
// - control changes during a run apply only after run restart, except clearing continuous.
// - pattern changes during a run apply only after run restart.
// - with a page selected, indices 16 to 30 reach that page.
// - page zero restores standard space; two selects page two.
// - force-idle setting sends low power idle and ignores MAC data.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "etg_defs.svh"

module etg_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic do_wr;
  logic do_rd;

  assign in_ready = count_reg != (AW+1)'(DEPTH);
  assign out_valid = count_reg != '0;
  assign out_data = mem[rd_ptr_reg];
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;

  always_ff @(posedge clock) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////

module etg_gen #(
  parameter int unsigned BLOCK_FRAMES = `ETG_BLOCK_FRAMES,
  parameter int unsigned BURST_FRAMES = `ETG_BURST_FRAMES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [6:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  input wire logic mac_tx_en,
  input wire logic [7:0] mac_tx_data,
  input wire logic tx_ready,
  output logic mdi_tx_en,
  output logic [7:0] mdi_tx_data,
  output logic mdi_tx_lpi
);
  import etg_pkg::*;

  localparam int BITS_PER_CYC = `ETG_LINE_MBPS / `ETG_CLK_MHZ;
  localparam logic [13:0] GAP_SHORT = 14'((`ETG_IPG_SHORT_BITS
    + BITS_PER_CYC - 1) / BITS_PER_CYC);
  localparam logic [13:0] GAP_LONG = 14'((`ETG_IPG_LONG_BITS
    + BITS_PER_CYC - 1) / BITS_PER_CYC);
  localparam logic [13:0] HDR_BYTES = 14'(2 * `ETG_ADDR_BYTES
    + `ETG_FCS_BYTES);

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `ETG_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  logic [15:0] ctrl1_reg;
  logic [15:0] pat_reg;
  logic [15:0] page_reg;
  logic lpi_reg;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic [15:0] rd_val;
  logic [4:0] idx;
  logic apb_wr;

  etg_state_t state_reg;
  etg_cfg_t cfg_reg;
  logic [13:0] bcnt_reg;
  logic [31:0] crc_reg;
  logic [15:0] lfsr_reg;
  logic [24:0] frame_cnt_reg;
  logic [13:0] block_cnt_reg;
  logic run_q_reg;
  logic done_reg;
  logic mdi_en_reg;
  logic [7:0] mdi_data_reg;
  logic mdi_lpi_reg;

  logic run_req;
  logic start;
  logic busy;
  logic push;
  logic last_byte;
  logic frame_end;
  logic burst_done;
  logic block_stop;
  logic stop_now;
  logic [13:0] flen;
  logic [13:0] seg_len;
  logic [31:0] fcs_val;
  etg_word_t word;
  etg_word_t fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic owns;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state so that every answer comes from a flop

  assign idx = paddr[6:2];
  assign apb_wr = psel & penable & pready_reg & pwrite;

  always_comb begin
    rd_val = 16'h0000;
    if (idx == `ETG_IDX_PAGE) begin
      rd_val = page_reg;
    end else if (idx > `ETG_IDX_STD_TOP) begin
      if (page_reg == `ETG_PAGE_ONE) begin
        case (idx)
          `ETG_IDX_CTRL1: rd_val = ctrl1_reg;
          `ETG_IDX_PAT: rd_val = pat_reg;
          `ETG_IDX_STAT: begin
            rd_val[`ETG_B_ST_BUSY] = busy;
            rd_val[`ETG_B_ST_DONE] = done_reg;
            rd_val[`ETG_B_ST_LPI] = mdi_lpi_reg;
          end
          default: rd_val = 16'h0000;
        endcase
      end else if (page_reg == `ETG_PAGE_TWO && idx == `ETG_IDX_EEE) begin
        rd_val[`ETG_B_LPI] = lpi_reg;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      if (psel && penable && !pready_reg) begin
        prdata_reg <= {16'h0000, rd_val};
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl1_reg <= `ETG_CTRL1_RST;
      pat_reg <= `ETG_PAT_RST;
      page_reg <= `ETG_PAGE_STD;
      lpi_reg <= 1'b0;
    end else if (apb_wr) begin
      if (idx == `ETG_IDX_PAGE) begin
        page_reg <= pwdata[15:0];
      end else if (page_reg == `ETG_PAGE_ONE && idx == `ETG_IDX_CTRL1) begin
        ctrl1_reg <= pwdata[15:0];
      end else if (page_reg == `ETG_PAGE_ONE && idx == `ETG_IDX_PAT) begin
        pat_reg <= pwdata[15:0];
      end else if (page_reg == `ETG_PAGE_TWO && idx == `ETG_IDX_EEE) begin
        lpi_reg <= pwdata[`ETG_B_LPI];
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer

  assign run_req = ctrl1_reg[`ETG_B_EN] & ctrl1_reg[`ETG_B_RUN];
  assign start = run_req & ~run_q_reg;
  assign busy = state_reg != ST_IDLE;
  assign push = busy & fifo_in_ready;

  always_comb begin
    case (cfg_reg.len)
      2'b00: flen = `ETG_LEN_00;
      2'b01: flen = `ETG_LEN_01;
      2'b10: flen = `ETG_LEN_10;
      default: flen = `ETG_LEN_11;
    endcase
    case (state_reg)
      ST_DA, ST_SA: seg_len = `ETG_ADDR_BYTES;
      ST_PAY: seg_len = flen - HDR_BYTES;
      ST_FCS: seg_len = `ETG_FCS_BYTES;
      ST_GAP: seg_len = cfg_reg.ipg ? GAP_LONG : GAP_SHORT;
      default: seg_len = 14'h0001;
    endcase
  end

  assign last_byte = bcnt_reg == seg_len - 14'h0001;
  assign frame_end = push & (state_reg == ST_FCS) & last_byte;
  assign burst_done = ~cfg_reg.dur
    & (frame_cnt_reg == 25'(BURST_FRAMES - 1));
  // continuous bit is read live so a run can be wound down at a block mark
  assign block_stop = cfg_reg.dur & ~ctrl1_reg[`ETG_B_DUR]
    & (block_cnt_reg == 14'(BLOCK_FRAMES - 1));
  assign stop_now = ~run_req | burst_done | block_stop;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      bcnt_reg <= 14'h0000;
      cfg_reg <= '0;
      run_q_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      run_q_reg <= run_req;
      if (start) begin
        state_reg <= ST_DA;
        bcnt_reg <= 14'h0000;
        done_reg <= 1'b0;
        cfg_reg.dur <= ctrl1_reg[`ETG_B_DUR];
        cfg_reg.len <= ctrl1_reg[`ETG_F_LEN_HI:`ETG_F_LEN_LO];
        cfg_reg.ipg <= ctrl1_reg[`ETG_B_IPG];
        cfg_reg.da <= ctrl1_reg[`ETG_F_DA_HI:`ETG_F_DA_LO];
        cfg_reg.sa <= ctrl1_reg[`ETG_F_SA_HI:`ETG_F_SA_LO];
        cfg_reg.pay <= ctrl1_reg[`ETG_B_PAY];
        cfg_reg.bad_fcs <= ctrl1_reg[`ETG_B_FCS];
        cfg_reg.pattern <= pat_reg;
      end else if (busy && !run_req && state_reg == ST_GAP) begin
        state_reg <= ST_IDLE;
      end else if (push) begin
        if (last_byte) begin
          bcnt_reg <= 14'h0000;
          case (state_reg)
            ST_DA: state_reg <= ST_SA;
            ST_SA: state_reg <= ST_PAY;
            ST_PAY: state_reg <= ST_FCS;
            ST_FCS: state_reg <= stop_now ? ST_IDLE : ST_GAP;
            ST_GAP: state_reg <= ST_DA;
            default: state_reg <= ST_IDLE;
          endcase
          if (frame_end && (burst_done || block_stop)) begin
            done_reg <= 1'b1;
          end
        end else begin
          bcnt_reg <= bcnt_reg + 14'h0001;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_cnt_reg <= '0;
      block_cnt_reg <= 14'h0000;
    end else if (start) begin
      frame_cnt_reg <= '0;
      block_cnt_reg <= 14'h0000;
    end else if (frame_end) begin
      frame_cnt_reg <= frame_cnt_reg + 25'h0000001;
      block_cnt_reg <= (block_cnt_reg == 14'(BLOCK_FRAMES - 1)) ?
        14'h0000 : block_cnt_reg + 14'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte datapath: crc and payload source

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      crc_reg <= `ETG_CRC_INIT;
      lfsr_reg <= `ETG_LFSR_SEED;
    end else begin
      if (start || !busy || state_reg == ST_GAP) begin
        crc_reg <= `ETG_CRC_INIT;
      end else if (push && state_reg != ST_FCS) begin
        crc_reg <= crc_byte(crc_reg, word.data);
      end
      // free-running across runs so restarts do not replay one sequence
      if (push && state_reg == ST_PAY) begin
        lfsr_reg <= lfsr_reg[0] ? ((lfsr_reg >> 1) ^ `ETG_LFSR_TAPS)
          : (lfsr_reg >> 1);
      end
    end
  end

  // keeping the register uninverted is enough to break the check
  assign fcs_val = cfg_reg.bad_fcs ? crc_reg : ~crc_reg;

  always_comb begin
    word.en = 1'b1;
    word.last = 1'b0;
    word.data = 8'h00;
    case (state_reg)
      ST_DA: word.data = last_byte ? {`ETG_NIB_ONES, cfg_reg.da}
        : `ETG_ALL_ONES;
      ST_SA: word.data = last_byte ? {`ETG_NIB_ONES, cfg_reg.sa}
        : `ETG_ALL_ONES;
      ST_PAY: begin
        if (cfg_reg.pay) begin
          word.data = lfsr_reg[7:0];
        end else begin
          word.data = bcnt_reg[0] ? cfg_reg.pattern[7:0]
            : cfg_reg.pattern[15:8];
        end
      end
      ST_FCS: begin
        word.data = 8'(fcs_val >> {bcnt_reg[1:0], 3'b000});
        word.last = last_byte;
      end
      default: word.en = 1'b0;
    endcase
  end

  etg_fifo #(
    .W($bits(etg_word_t)),
    .DEPTH(`ETG_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(busy),
    .in_ready(fifo_in_ready),
    .in_data(word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // medium side mux

  assign owns = busy | fifo_out_valid;
  assign fifo_out_ready = tx_ready & ~lpi_reg & owns;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mdi_en_reg <= 1'b0;
      mdi_data_reg <= 8'h00;
      mdi_lpi_reg <= 1'b0;
    end else if (lpi_reg) begin
      mdi_en_reg <= 1'b0;
      mdi_data_reg <= 8'h00;
      mdi_lpi_reg <= 1'b1;
    end else if (owns) begin
      mdi_lpi_reg <= 1'b0;
      mdi_en_reg <= fifo_out_valid & tx_ready & fifo_out.en;
      mdi_data_reg <= (fifo_out_valid && tx_ready) ? fifo_out.data : 8'h00;
    end else begin
      mdi_lpi_reg <= 1'b0;
      mdi_en_reg <= mac_tx_en;
      mdi_data_reg <= mac_tx_data;
    end
  end

  assign mdi_tx_en = mdi_en_reg;
  assign mdi_tx_data = mdi_data_reg;
  assign mdi_tx_lpi = mdi_lpi_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_leave_idle_run: assert property (@(posedge clock) disable iff (rst)
    !busy ##1 busy |-> $past(run_req))
    else $error("generator left idle without run request");

  a_burst_bound: assert property (@(posedge clock) disable iff (rst)
    frame_end && burst_done |=> !busy && done_reg)
    else $error("burst did not stop at its frame count");

  a_block_mark: assert property (@(posedge clock) disable iff (rst)
    frame_end && block_stop && !start |=> state_reg == ST_IDLE)
    else $error("continuous run overran the block mark");

  a_gap_bound: assert property (@(posedge clock) disable iff (rst)
    state_reg == ST_GAP |-> bcnt_reg < (cfg_reg.ipg ? GAP_LONG
      : GAP_SHORT))
    else $error("interframe gap too long");

  a_da_nibble: assert property (@(posedge clock) disable iff (rst)
    push && state_reg == ST_DA && last_byte |->
      fifo_in_ready && word.data[3:0] == cfg_reg.da)
    else $error("destination nibble wrong");

  a_sa_prefix: assert property (@(posedge clock) disable iff (rst)
    push && state_reg == ST_SA && !last_byte |->
      word.data == `ETG_ALL_ONES)
    else $error("source address prefix not all ones");

  a_cfg_frozen: assert property (@(posedge clock) disable iff (rst)
    busy && !start ##1 !start |-> $stable(cfg_reg))
    else $error("run settings changed without restart");

  a_page_gate: assert property (@(posedge clock) disable iff (rst)
    psel && penable && !pready_reg && idx == `ETG_IDX_CTRL1
      && page_reg != `ETG_PAGE_ONE |=> prdata_reg == 32'h00000000)
    else $error("control read leaked outside its page");

  a_page_write: assert property (@(posedge clock) disable iff (rst)
    apb_wr && idx == `ETG_IDX_PAGE |=>
      page_reg == $past(pwdata[15:0]))
    else $error("page select not updated");

  a_lpi_force: assert property (@(posedge clock) disable iff (rst)
    lpi_reg |=> mdi_lpi_reg && !mdi_en_reg)
    else $error("low power idle not forced");

  a_mac_pass: assert property (@(posedge clock) disable iff (rst)
    !lpi_reg && !owns |=> mdi_en_reg == $past(mac_tx_en)
      && mdi_data_reg == $past(mac_tx_data))
    else $error("mac traffic not passed through");

  c_run_start: cover property (@(posedge clock) disable iff (rst)
    start ##1 busy);
  c_frame_done: cover property (@(posedge clock) disable iff (rst)
    frame_end ##1 state_reg == ST_GAP);
  c_lpi_on: cover property (@(posedge clock) disable iff (rst)
    $rose(mdi_lpi_reg));
endmodule

// ### etg_partner.sv
`timescale 1ns/1ps

// copper link partner: takes bytes off the medium, measures frames and gaps
module etg_partner (
  input wire logic clock,
  input wire logic rst,
  input wire logic mdi_tx_en,
  input wire logic [7:0] mdi_tx_data,
  input wire logic stall,
  output logic tx_ready,
  output int frames,
  output int last_len,
  output int last_gap
);
  logic [7:0] byte_mem [0:10015];
  int cnt;
  int idle;

  // slow answer: the medium refuses bytes while stalled
  assign tx_ready = !stall;

  ////////////////////////////////////////////////////////////////////////////

  // a frame ends at the first idle slot; gap counts idle slots between frames
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      idle <= 0;
      frames <= 0;
      last_len <= 0;
      last_gap <= 0;
    end else if (mdi_tx_en) begin
      if (cnt < 10016) begin
        byte_mem[cnt] <= mdi_tx_data;
      end
      cnt <= cnt + 1;
      if (cnt == 0) begin
        last_gap <= idle;
      end
    end else if (cnt != 0) begin
      frames <= frames + 1;
      last_len <= cnt;
      cnt <= 0;
      idle <= 1;
    end else begin
      idle <= idle + 1;
    end
  end
endmodule

// ### test_ethernet_test_packet_generator.sv
`timescale 1ns/1ps
`include "etg_defs.svh"

`define CHK(nm, exp, got) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, got); \
  end \
end

module test_ethernet_test_packet_generator;
  import etg_pkg::*;
  localparam int BLOCK = 3;
  localparam int BURST = 5;
  localparam int LIMIT = 60000;
  localparam int LENS [4] = '{125, 64, 1518, 10000};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [6:0] paddr = 7'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic mac_tx_en = 1'b0;
  logic [7:0] mac_tx_data = 8'h00;
  logic tx_ready;
  logic mdi_tx_en;
  logic [7:0] mdi_tx_data;
  logic mdi_tx_lpi;
  logic stall = 1'b0;
  int frames;
  int last_len;
  int last_gap;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  int f0;
  logic [31:0] rd;
  logic [15:0] c;
  logic [15:0] p;
  logic [1:0] lc;

  always #4 clock = ~clock;

  etg_gen #(.BLOCK_FRAMES(BLOCK), .BURST_FRAMES(BURST)) DUT (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .mac_tx_en(mac_tx_en), .mac_tx_data(mac_tx_data),
    .tx_ready(tx_ready), .mdi_tx_en(mdi_tx_en), .mdi_tx_data(mdi_tx_data),
    .mdi_tx_lpi(mdi_tx_lpi)
  );

  etg_partner P (
    .clock(clock), .rst(rst), .mdi_tx_en(mdi_tx_en),
    .mdi_tx_data(mdi_tx_data), .stall(stall), .tx_ready(tx_ready),
    .frames(frames), .last_len(last_len), .last_gap(last_gap)
  );

  ////////////////////////////////////////////////////////////////////////////

  task automatic apb(input logic w, input logic [4:0] idx,
      input logic [15:0] wd, output logic [31:0] rv);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    apb(1'b1, idx, d, rd);
  endtask

  task automatic rd_chk(input string nm, input logic [4:0] idx,
      input logic [31:0] exp);
    apb(1'b0, idx, 16'h0000, rd);
    `CHK(nm, exp, rd)
  endtask

  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (frames < n && k < 30000) begin
      @(posedge clock);
      k++;
    end
    `CHK("frames", n, frames)
  endtask

  task automatic idle_wait;
    int k;
    k = 0;
    rd = 32'h00000001;
    while (rd[0] !== 1'b0 && k < 100) begin
      apb(1'b0, `ETG_IDX_STAT, 16'h0000, rd);
      k++;
    end
    // a generator that never idles counts here, not only in the timeout
    `CHK("idle", 1'b0, rd[0])
  endtask

  function automatic logic [15:0] ctl(input logic run, dur,
      input logic [1:0] len, input logic ipg, input logic [3:0] da, sa,
      input logic pay, fcs);
    return {1'b1, run, dur, len, ipg, da, sa, pay, fcs};
  endfunction

  // reflected crc-32; the caller inverts it for a good check sequence
  function automatic logic [31:0] crc_of(input int n);
    logic [31:0] r;
    r = 32'hffffffff;
    for (int i = 0; i < n; i++) begin
      r = r ^ {24'h000000, P.byte_mem[i]};
      for (int b = 0; b < 8; b++) begin
        r = r[0] ? ((r >> 1) ^ 32'hedb88320) : (r >> 1);
      end
    end
    return r;
  endfunction

  task automatic check_frame(input int len, input logic [3:0] da, sa,
      input logic pay, fcs, input logic [15:0] pat);
    logic [47:0] a;
    logic [47:0] s;
    logic [31:0] f;
    logic [31:0] r;
    int bad;
    a = '0;
    s = '0;
    bad = 0;
    for (int i = 0; i < 6; i++) begin
      a = {a[39:0], P.byte_mem[i]};
      s = {s[39:0], P.byte_mem[i + 6]};
    end
    for (int i = 12; i < len - 4; i++) begin
      if (P.byte_mem[i] !== (i[0] ? pat[7:0] : pat[15:8])) bad++;
    end
    f = {P.byte_mem[len - 1], P.byte_mem[len - 2], P.byte_mem[len - 3],
         P.byte_mem[len - 4]};
    r = crc_of(len - 4);
    `CHK("length", len, last_len)
    `CHK("dest", {44'hfffffffffff, da}, a)
    `CHK("src", {44'hfffffffffff, sa}, s)
    if (pay) `CHK("random", 1'b1, bad > 0)
    else `CHK("payload", 0, bad)
    `CHK("fcs", fcs ? r : ~r, f)
  endtask

  // one frame, then run cleared: the frame in flight ends the run
  task automatic run_one(input logic [15:0] cv, input logic [15:0] pv,
      input logic st);
    int g;
    g = frames;
    stall <= st;
    wr(`ETG_IDX_PAT, pv);
    wr(`ETG_IDX_CTRL1, cv);
    if (st) begin
      repeat (30) @(posedge clock);
      `CHK("stalled", 1'b0, mdi_tx_en)
      stall <= 1'b0;
    end
    wait_frames(g + 1);
    wr(`ETG_IDX_CTRL1, cv & 16'hbfff);
    idle_wait;
    `CHK("one_frame", g + 1, frames)
  endtask

  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      report_and_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd_chk("page", `ETG_IDX_PAGE, 32'h00000000);
    rd_chk("std29", `ETG_IDX_CTRL1, 32'h00000000);
    wr(`ETG_IDX_PAGE, `ETG_PAGE_ONE);
    rd_chk("ctrl1", `ETG_IDX_CTRL1, 32'h00000040);
    rd_chk("pat", `ETG_IDX_PAT, 32'h00000000);
    rd_chk("low", 5'h02, 32'h00000000);
    wr(`ETG_IDX_PAT, 16'hc3a5);
    rd_chk("pat_rw", `ETG_IDX_PAT, 32'h0000c3a5);
    wr(`ETG_IDX_PAGE, `ETG_PAGE_TWO);
    rd_chk("eee", `ETG_IDX_EEE, 32'h00000000);
    rd_chk("p2_29", `ETG_IDX_CTRL1, 32'h00000000);
    wr(`ETG_IDX_PAGE, `ETG_PAGE_STD);
    rd_chk("std30", `ETG_IDX_PAT, 32'h00000000);
    wr(`ETG_IDX_PAGE, `ETG_PAGE_ONE);
    end_test("registers");
    mac_tx_data <= 8'h3c;
    mac_tx_en <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK("mac_en", 1'b1, mdi_tx_en)
    `CHK("mac_data", 8'h3c, mdi_tx_data)
    wr(`ETG_IDX_PAGE, `ETG_PAGE_TWO);
    wr(`ETG_IDX_EEE, 16'h0010);
    repeat (3) @(posedge clock);
    `CHK("lpi", 1'b1, mdi_tx_lpi)
    `CHK("lpi_en", 1'b0, mdi_tx_en)
    wr(`ETG_IDX_PAGE, `ETG_PAGE_ONE);
    rd_chk("lpi_stat", `ETG_IDX_STAT, 32'h00000004);
    wr(`ETG_IDX_PAGE, `ETG_PAGE_TWO);
    wr(`ETG_IDX_EEE, 16'h0000);
    mac_tx_en <= 1'b0;
    wr(`ETG_IDX_PAGE, `ETG_PAGE_ONE);
    end_test("mac_lpi");
    for (int k = 0; k < 4; k++) begin
      lc = k[1:0];
      p = {8'h5a, 6'h00, lc};
      c = ctl(1'b1, 1'b0, lc, 1'b0, 4'h2 + lc, 4'he - lc, 1'b0, lc[1]);
      run_one(c, p, k == 0);
      check_frame(LENS[k], 4'h2 + lc, 4'he - lc, 1'b0, lc[1], p);
    end
    run_one(ctl(1'b1, 1'b0, 2'b01, 1'b0, 4'h7, 4'h9, 1'b1, 1'b0),
            16'h0000, 1'b0);
    check_frame(64, 4'h7, 4'h9, 1'b1, 1'b0, 16'h0000);
    end_test("lengths");
    f0 = frames;
    c = ctl(1'b1, 1'b0, 2'b01, 1'b1, 4'h1, 4'h0, 1'b0, 1'b0);
    wr(`ETG_IDX_CTRL1, c);
    wait_frames(f0 + BURST);
    `CHK("gap_long", `ETG_IPG_LONG_BITS / 8, last_gap)
    repeat (1500) @(posedge clock);
    `CHK("burst_stop", f0 + BURST, frames)
    rd_chk("done", `ETG_IDX_STAT, 32'h00000002);
    wr(`ETG_IDX_CTRL1, c & 16'hbfff);
    end_test("burst");
    f0 = frames;
    wr(`ETG_IDX_PAT, 16'h1111);
    c = ctl(1'b1, 1'b0, 2'b01, 1'b0, 4'h1, 4'h0, 1'b0, 1'b0);
    wr(`ETG_IDX_CTRL1, c);
    wait_frames(f0 + 1);
    wr(`ETG_IDX_PAT, 16'h2222);
    wr(`ETG_IDX_CTRL1, ctl(1'b1, 1'b0, 2'b00, 1'b0, 4'h4, 4'h4, 1'b0,
       1'b0));
    wait_frames(f0 + 3);
    check_frame(64, 4'h1, 4'h0, 1'b0, 1'b0, 16'h1111);
    `CHK("gap_short", `ETG_IPG_SHORT_BITS / 8, last_gap)
    wr(`ETG_IDX_CTRL1, c & 16'hbfff);
    idle_wait;
    c = ctl(1'b1, 1'b0, 2'b00, 1'b0, 4'h4, 4'h4, 1'b0, 1'b0);
    run_one(c, 16'h2222, 1'b0);
    check_frame(125, 4'h4, 4'h4, 1'b0, 1'b0, 16'h2222);
    end_test("restart");
    f0 = frames;
    wr(`ETG_IDX_CTRL1, ctl(1'b1, 1'b1, 2'b01, 1'b0, 4'h1, 4'h0, 1'b0, 1'b0));
    wait_frames(f0 + BLOCK + 1);
    c = ctl(1'b1, 1'b0, 2'b01, 1'b0, 4'h1, 4'h0, 1'b0, 1'b0);
    wr(`ETG_IDX_CTRL1, c);
    repeat (600) @(posedge clock);
    `CHK("block_stop", f0 + 2 * BLOCK, frames)
    wr(`ETG_IDX_CTRL1, c & 16'hbfff);
    end_test("continuous");
    report_and_stop;
  end
endmodule
